/* efbl_pkg.sv */
// efbl_pkg: constants and carrier types for the fifo buffering and level block
package efbl_pkg;
    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int ADDR_W = 8;
    localparam logic [7:0] OFF_RX_DATAPATH_CONTROL = 8'h78;
    localparam logic [7:0] OFF_RX_FIFO_LEVELS = 8'h7C;
    localparam logic [7:0] OFF_TX_FIFO_LEVELS = 8'h80;
    localparam int SKIP_BIT = 31;
    localparam int SKIP_LANE = 3;
    localparam int STAT_LSB = 16;
    localparam int STAT_MSB = 23;
    localparam int DATA_LSB = 0;
    localparam int DATA_MSB = 15;
    localparam logic [7:0] RST_STATUS_USED = 8'h00;
    localparam logic [15:0] RST_RX_DATA_USED = 16'h0000;
    localparam logic [15:0] RST_TX_DATA_FREE = 16'h1200;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // ****************************************************************
    // sizes
    // ****************************************************************
    localparam int TX_BUF_BYTES = 2048;
    localparam int RX_BUF_BYTES = 128;
    localparam int TX_BUF_WORDS = TX_BUF_BYTES / 4;
    localparam int RX_BUF_WORDS = RX_BUF_BYTES / 4;
    localparam int TX_PTR_W = $clog2(TX_BUF_WORDS) + 1;
    localparam int RX_PTR_W = $clog2(RX_BUF_WORDS) + 1;
    localparam logic [16:0] TOTAL_FIFO_BYTES = 17'h04000;
    localparam logic [16:0] ALLOC_UNIT_BYTES = 17'h00400;
    localparam logic [16:0] TX_STATUS_BYTES = 17'h00200;
    localparam logic [16:0] RX_FULL_MARGIN = 17'h00010;
    localparam logic [15:0] WORD_BYTES = 16'h0004;
    // ****************************************************************
    // carriers
    // ****************************************************************
    typedef struct packed {
        logic valid;
        logic last;
        logic [31:0] data;
    } efbl_stream_t;
    typedef struct packed {
        logic aw_full;
        logic [7:0] aw_addr;
        logic w_full;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic skip;
        logic [15:0] tx_free;
        logic [7:0] tx_stat;
        logic [15:0] rx_used;
        logic [7:0] rx_stat;
        logic [31:0] lost;
        logic drop;
        logic drop_frame;
        logic rx_mid;
        logic [TX_PTR_W-1:0] txm_wp;
        logic [TX_PTR_W-1:0] txm_rp;
        logic [RX_PTR_W-1:0] rxm_wp;
        logic [RX_PTR_W-1:0] rxm_rp;
    } efbl_state_t;
endpackage

/* efbl_top.sv */
// efbl_top: mac-side buffers, rx skip control and host fifo level registers
// Behaviour
// - fixed mac-side buffers: 2K bytes transmit, 128 bytes receive, not host sizable
// - move host transmit data into transmit mac-side buffer whenever it has room
// - transmit mac-side buffer holds up to two frames besides queued host data; the code limits it only by its 512 words, not by frame count
// - receive path: mac, mac-side buffer, receive data fifo; buffer fills when fifo full
// - after receive buffer overrun, drop incoming frames until receive data fifo frees room
// - count each receive frame dropped by overrun in the lost frame counter
// - reported host fifo levels exclude mac-side buffer contents, which stay hidden
// - writing one to bit 31 at 78h skips receive data to next frame start
// - skip bit reads one while the skip is in progress
// - 7Ch bits 23-16 give receive status fifo use in dwords, reset zero
// - 7Ch bits 15-0 give receive data use in bytes, whole dwords per frame
// - 80h bits 23-16 give transmit status fifo use in dwords, reset zero
// - 80h bits 15-0 give free transmit data bytes, reset 1200h
// - transmit status fifo takes fixed 512 bytes of transmit allocation
// - receive allocation is 16384 minus transmit; one sixteenth is status
// - receive data fifo counts as full within 4 dwords of its capacity
//
// Chosen here: register access over AXI4-Lite.
module efbl_top
    import efbl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [efbl_pkg::ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [efbl_pkg::ADDR_W-1:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    input wire logic [3:0] tx_allocation_size,
    input wire efbl_pkg::efbl_stream_t tx_fifo_in,
    output logic tx_fifo_ready,
    input wire logic tx_host_write,
    output efbl_pkg::efbl_stream_t mac_tx_out,
    input wire logic mac_tx_ready,
    input wire logic tx_status_push,
    input wire logic tx_status_pop,
    input wire efbl_pkg::efbl_stream_t mac_rx_in,
    output efbl_pkg::efbl_stream_t rx_fifo_out,
    input wire logic rx_fifo_ready,
    output logic rx_status_push,
    input wire logic rx_status_pop,
    input wire logic rx_host_read,
    input wire logic rx_head_valid,
    input wire logic rx_head_last,
    output logic rx_skip_drain,
    output logic [31:0] rx_lost_frames
);
    import efbl_pkg::*;

    // ****************************************************************
    // state and storage
    // ****************************************************************
    efbl_state_t r;
    efbl_state_t next_r;
    logic [32:0] tx_mem [TX_BUF_WORDS];
    logic [32:0] rx_mem [RX_BUF_WORDS];

    logic [TX_PTR_W-1:0] txm_count;
    logic [RX_PTR_W-1:0] rxm_count;
    logic txm_full;
    logic rxm_full;
    logic tx_take;
    logic tx_send;
    logic rx_keep;
    logic rx_lose;
    logic rx_new_loss;
    logic rx_move;
    logic rx_full;
    logic rx_pop;
    logic wr_go;
    logic skip_req;
    logic [16:0] tx_alloc;
    logic [16:0] rx_alloc;
    logic [16:0] rx_data_cap;
    logic [16:0] rx_used_w;

    assign txm_count = r.txm_wp - r.txm_rp;
    assign rxm_count = r.rxm_wp - r.rxm_rp;
    assign txm_full = txm_count == TX_PTR_W'(TX_BUF_WORDS);
    assign rxm_full = rxm_count == RX_PTR_W'(RX_BUF_WORDS);

    // ****************************************************************
    // fifo geometry from the allocation setting
    // ****************************************************************
    // the transmit side needs no capacity here: its free count is tracked by events
    assign tx_alloc = {3'h0, tx_allocation_size, 10'h000};
    assign rx_alloc = TOTAL_FIFO_BYTES - tx_alloc;
    assign rx_data_cap = rx_alloc - {4'h0, rx_alloc[16:4]};
    assign rx_used_w = {1'b0, r.rx_used};
    assign rx_full = (rx_used_w + RX_FULL_MARGIN) >= rx_data_cap;

    // ****************************************************************
    // transmit path
    // ****************************************************************
    assign tx_fifo_ready = !txm_full;
    assign tx_take = tx_fifo_in.valid && !txm_full;
    assign mac_tx_out.valid = txm_count != '0;
    assign mac_tx_out.last = tx_mem[r.txm_rp[TX_PTR_W-2:0]][32];
    assign mac_tx_out.data = tx_mem[r.txm_rp[TX_PTR_W-2:0]][31:0];
    assign tx_send = mac_tx_out.valid && mac_tx_ready;

    // ****************************************************************
    // receive path
    // ****************************************************************
    // mid-frame overrun truncates the frame already in the buffer; the mac
    // has no back-pressure, so nothing better is possible at this point
    assign rx_lose = mac_rx_in.valid
        && (r.rx_mid ? (r.drop_frame || rxm_full) : (r.drop || rxm_full));
    assign rx_new_loss = rx_lose && (!r.rx_mid || !r.drop_frame);
    assign rx_keep = mac_rx_in.valid && !rx_lose;
    assign rx_fifo_out.valid = (rxm_count != '0) && !rx_full;
    assign rx_fifo_out.last = rx_mem[r.rxm_rp[RX_PTR_W-2:0]][32];
    assign rx_fifo_out.data = rx_mem[r.rxm_rp[RX_PTR_W-2:0]][31:0];
    assign rx_move = rx_fifo_out.valid && rx_fifo_ready;
    assign rx_status_push = rx_move && rx_fifo_out.last;
    assign rx_skip_drain = r.skip && rx_head_valid;
    assign rx_pop = rx_host_read || rx_skip_drain;

    // ****************************************************************
    // bus handshakes
    // ****************************************************************
    assign s_axi_awready = !r.aw_full && !r.bvalid;
    assign s_axi_wready = !r.w_full && !r.bvalid;
    assign s_axi_arready = !r.rvalid;
    assign s_axi_bvalid = r.bvalid;
    assign s_axi_bresp = r.bresp;
    assign s_axi_rvalid = r.rvalid;
    assign s_axi_rdata = r.rdata;
    assign s_axi_rresp = r.rresp;
    assign wr_go = r.aw_full && r.w_full && !r.bvalid;
    assign skip_req = wr_go && r.aw_addr == OFF_RX_DATAPATH_CONTROL && r.w_strb[SKIP_LANE]
        && r.w_data[SKIP_BIT];
    assign rx_lost_frames = r.lost;

    always_comb begin
        next_r = r;
        // skip ends on the drained word that closes the frame; a new request
        // in the same cycle is applied below and wins, so it is never lost
        if (rx_skip_drain && rx_head_last) begin
            next_r.skip = 1'b0;
        end
        // write address and data are taken in either order
        if (s_axi_awvalid && s_axi_awready) begin
            next_r.aw_full = 1'b1;
            next_r.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_r.w_full = 1'b1;
            next_r.w_data = s_axi_wdata;
            next_r.w_strb = s_axi_wstrb;
        end
        if (wr_go) begin
            next_r.aw_full = 1'b0;
            next_r.w_full = 1'b0;
            next_r.bvalid = 1'b1;
            unique case (r.aw_addr)
                OFF_RX_DATAPATH_CONTROL, OFF_RX_FIFO_LEVELS, OFF_TX_FIFO_LEVELS: begin
                    next_r.bresp = RESP_OKAY;
                end
                default: begin
                    next_r.bresp = RESP_SLVERR;
                end
            endcase
            if (skip_req) begin
                next_r.skip = 1'b1;
            end
        end
        if (r.bvalid && s_axi_bready) begin
            next_r.bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_r.rvalid = 1'b1;
            next_r.rdata = '0;
            next_r.rresp = RESP_OKAY;
            unique case (s_axi_araddr)
                OFF_RX_DATAPATH_CONTROL: begin
                    next_r.rdata[SKIP_BIT] = r.skip;
                end
                OFF_RX_FIFO_LEVELS: begin
                    next_r.rdata[STAT_MSB:STAT_LSB] = r.rx_stat;
                    next_r.rdata[DATA_MSB:DATA_LSB] = r.rx_used;
                end
                OFF_TX_FIFO_LEVELS: begin
                    next_r.rdata[STAT_MSB:STAT_LSB] = r.tx_stat;
                    next_r.rdata[DATA_MSB:DATA_LSB] = r.tx_free;
                end
                default: begin
                    next_r.rresp = RESP_SLVERR;
                end
            endcase
        end
        if (r.rvalid && s_axi_rready) begin
            next_r.rvalid = 1'b0;
        end
        // host fifo levels count only host fifo words
        next_r.tx_free = r.tx_free + (tx_take ? WORD_BYTES : 16'h0000)
            - (tx_host_write ? WORD_BYTES : 16'h0000);
        next_r.tx_stat = r.tx_stat + {7'h00, tx_status_push}
            - {7'h00, tx_status_pop};
        next_r.rx_used = r.rx_used + (rx_move ? WORD_BYTES : 16'h0000)
            - (rx_pop ? WORD_BYTES : 16'h0000);
        next_r.rx_stat = r.rx_stat + {7'h00, rx_status_push}
            - {7'h00, rx_status_pop};
        // mac-side buffers
        if (tx_take) begin
            next_r.txm_wp = r.txm_wp + TX_PTR_W'(1);
        end
        if (tx_send) begin
            next_r.txm_rp = r.txm_rp + TX_PTR_W'(1);
        end
        if (rx_move) begin
            next_r.rxm_rp = r.rxm_rp + RX_PTR_W'(1);
        end
        if (rx_pop && r.drop) begin
            next_r.drop = 1'b0;
        end
        if (mac_rx_in.valid) begin
            next_r.rx_mid = !mac_rx_in.last;
            next_r.drop_frame = rx_lose && !mac_rx_in.last;
            if (rx_lose) begin
                next_r.drop = 1'b1;
            end else begin
                next_r.rxm_wp = r.rxm_wp + RX_PTR_W'(1);
            end
        end
        if (rx_new_loss) begin
            next_r.lost = r.lost + 32'h0000_0001;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            r <= '0;
            r.tx_free <= RST_TX_DATA_FREE;
            r.tx_stat <= RST_STATUS_USED;
            r.rx_used <= RST_RX_DATA_USED;
            r.rx_stat <= RST_STATUS_USED;
        end else begin
            r <= next_r;
        end
    end

    // storage carries no reset; only pointers define its contents
    always_ff @(posedge clock) begin
        if (tx_take) begin
            tx_mem[r.txm_wp[TX_PTR_W-2:0]] <= {tx_fifo_in.last, tx_fifo_in.data};
        end
        if (rx_keep) begin
            rx_mem[r.rxm_wp[RX_PTR_W-2:0]] <= {mac_rx_in.last, mac_rx_in.data};
        end
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    sequence s_skip_start;
        skip_req;
    endsequence
    sequence s_skip_end;
        rx_skip_drain && rx_head_last;
    endsequence

    a_skip_sets: assert property (@(posedge clock) disable iff (!rst_b)
        s_skip_start |=> r.skip)
        else $error("skip bit not set by write");
    a_skip_holds: assert property (@(posedge clock) disable iff (!rst_b)
        r.skip && !(rx_skip_drain && rx_head_last) |=> r.skip)
        else $error("skip bit dropped early");
    a_skip_clears: assert property (@(posedge clock) disable iff (!rst_b)
        s_skip_end and !skip_req |=> !r.skip)
        else $error("skip bit not cleared at frame end");
    a_level_reset: assert property (@(posedge clock)
        !rst_b |=> r.tx_free == RST_TX_DATA_FREE && r.rx_used == '0 && r.tx_stat == '0)
        else $error("level reset values wrong");
    a_lost_count: assert property (@(posedge clock) disable iff (!rst_b)
        rx_new_loss |=> r.lost == $past(r.lost) + 32'h0000_0001)
        else $error("lost frame not counted");
    a_rx_full_stop: assert property (@(posedge clock) disable iff (!rst_b)
        rx_full |-> !rx_move)
        else $error("data moved into full receive fifo");
    a_tx_room_move: assert property (@(posedge clock) disable iff (!rst_b)
        tx_fifo_in.valid && !txm_full && !tx_send |=> txm_count == $past(txm_count) + 1'b1)
        else $error("transmit data not moved into free room");
    a_rx_read_levels: assert property (@(posedge clock) disable iff (!rst_b)
        s_axi_arvalid && s_axi_arready && s_axi_araddr == OFF_RX_FIFO_LEVELS
        |=> r.rvalid && r.rdata[DATA_MSB:DATA_LSB] == $past(r.rx_used)
            && r.rdata[STAT_MSB:STAT_LSB] == $past(r.rx_stat))
        else $error("receive level read wrong");
    a_drop_after_overrun: assert property (@(posedge clock) disable iff (!rst_b)
        rx_lose ##1 (!rx_pop && mac_rx_in.valid && !r.rx_mid) |-> !rx_keep)
        else $error("frame accepted during overrun");
endmodule // efbl_top

/* efbl_mac_model.sv */
// efbl_mac_model: behavioural mac that sends receive frames and sinks transmit words
module efbl_mac_model
    import efbl_pkg::*;
(
    input wire logic clock,
    input wire logic rst_b,
    input wire logic stall,
    output efbl_pkg::efbl_stream_t mac_rx_in,
    input wire efbl_pkg::efbl_stream_t mac_tx_out,
    output logic mac_tx_ready,
    output int tx_taken
);
    timeunit 1ns;
    timeprecision 1ns;
    import efbl_pkg::*;
    logic [31:0] seq;
    initial begin
        mac_rx_in = '0;
        seq = 32'h0;
    end
    // stall holds the transmit side back so the buffer can fill up
    assign mac_tx_ready = !stall;
    always @(posedge clock) begin
        if (!rst_b) begin
            tx_taken <= 0;
        end else if (mac_tx_out.valid && mac_tx_ready) begin
            tx_taken <= tx_taken + 1;
        end
    end
    // no back-pressure on receive: one word per cycle, as a real mac
    task automatic send(input int n);
        for (int i = 0; i < n; i++) begin
            @(posedge clock);
            mac_rx_in <= {1'b1, i == n - 1, seq};
            seq = seq + 32'h1;
        end
        @(posedge clock);
        // idle data inverted so a stale word never passes for fresh data
        mac_rx_in <= {1'b0, 1'b0, ~seq};
    endtask
endmodule // efbl_mac_model

/* ethernet_fifo_buffering_levels_test.sv */
// ethernet_fifo_buffering_levels_test: register level bench for the fifo buffering block
module ethernet_fifo_buffering_levels_test;
    timeunit 1ns;
    timeprecision 1ns;
    import efbl_pkg::*;
    // ****************************************************************
    // signals and instances
    // ****************************************************************
    logic clock = 0, rst_b = 0, s_axi_awvalid = 0, s_axi_awready, s_axi_wvalid = 0, s_axi_wready;
    logic [7:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, rx_lost_frames;
    logic [3:0] s_axi_wstrb = 4'hF, tx_allocation_size = 4'h6;
    logic s_axi_bvalid, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready = 0, tx_fifo_ready, tx_host_write = 0, mac_tx_ready, tx_status_push = 0;
    logic tx_status_pop = 0, rx_fifo_ready = 1, rx_status_push, rx_status_pop = 0;
    logic rx_host_read = 0, rx_head_valid = 0, rx_head_last = 0, rx_skip_drain, stall = 0;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    efbl_stream_t tx_fifo_in = '0, mac_tx_out, mac_rx_in, rx_fifo_out;
    int failures = 0, tests_run = 0, tx_taken, tx_in = 0, rx_words = 0, pushes = 0, drains = 0;
    logic [31:0] lost0, tx_seen = '0;
    logic [32:0] rx_seen = '0;
    localparam int HOST_WR = 0, TX_ST_PUSH = 1, TX_ST_POP = 2, RX_ST_POP = 3, HOST_RD = 4;
    efbl_top efbl_top_inst (.clock, .rst_b, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr,
        .s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
        .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
        .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .tx_allocation_size, .tx_fifo_in,
        .tx_fifo_ready, .tx_host_write, .mac_tx_out, .mac_tx_ready, .tx_status_push,
        .tx_status_pop, .mac_rx_in, .rx_fifo_out, .rx_fifo_ready, .rx_status_push,
        .rx_status_pop, .rx_host_read, .rx_head_valid, .rx_head_last, .rx_skip_drain,
        .rx_lost_frames);
    efbl_mac_model efbl_mac_model_inst (.clock, .rst_b, .stall, .mac_rx_in, .mac_tx_out,
        .mac_tx_ready, .tx_taken);
    initial begin
        forever #50 clock = ~clock;
    end
    always @(posedge clock) begin
        tx_in <= tx_in + int'(tx_fifo_in.valid && tx_fifo_ready);
        rx_words <= rx_words + int'(rx_fifo_out.valid && rx_fifo_ready);
        pushes <= pushes + int'(rx_status_push === 1'b1);
        drains <= drains + int'(rx_skip_drain === 1'b1);
        if (rx_fifo_out.valid && rx_fifo_ready) rx_seen <= {rx_fifo_out.last, rx_fifo_out.data};
        if (mac_tx_out.valid && mac_tx_ready) tx_seen <= mac_tx_out.data;
    end
    // ****************************************************************
    // tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 0;
        w = 0;
        @(posedge clock);
        {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, d, 3'b111};
        while (!(aw && w)) begin
            @(negedge clock);
            aw = aw | (s_axi_awvalid && s_axi_awready);
            w = w | (s_axi_wvalid && s_axi_wready);
            @(posedge clock);
            if (aw) s_axi_awvalid <= 0;
            if (w) s_axi_wvalid <= 0;
        end
        do @(negedge clock); while (s_axi_bvalid !== 1'b1);
        chk(32'(s_axi_bresp), 32'(er));
        @(posedge clock);
        s_axi_bready <= 0;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge clock);
        {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
        do @(negedge clock); while (s_axi_arready !== 1'b1);
        @(posedge clock);
        s_axi_arvalid <= 0;
        do @(negedge clock); while (s_axi_rvalid !== 1'b1);
        chk(s_axi_rdata, ed);
        chk(32'(s_axi_rresp), 32'(er));
        @(posedge clock);
        s_axi_rready <= 0;
    endtask
    task automatic set_line(input int k, input logic v);
        case (k)
            HOST_WR: tx_host_write <= v;
            TX_ST_PUSH: tx_status_push <= v;
            TX_ST_POP: tx_status_pop <= v;
            RX_ST_POP: rx_status_pop <= v;
            default: rx_host_read <= v;
        endcase
    endtask
    task automatic pulse(input int k, input int n);
        repeat (n) begin
            @(posedge clock);
            set_line(k, 1'b1);
            @(posedge clock);
            set_line(k, 1'b0);
        end
    endtask
    task automatic summarize();
        $display("comparisons %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clock);
        failures++;
        summarize();
    end
    // ****************************************************************
    // tests
    // ****************************************************************
    initial begin
        repeat (12) @(posedge clock);
        rst_b <= 1;
        rd(OFF_RX_DATAPATH_CONTROL, 32'h0, RESP_OKAY);
        rd(OFF_RX_FIFO_LEVELS, 32'h0, RESP_OKAY);
        rd(OFF_TX_FIFO_LEVELS, 32'h0000_1200, RESP_OKAY);
        rd(8'h84, 32'h0, RESP_SLVERR);
        wr(8'h84, 32'hFFFF_FFFF, RESP_SLVERR);
        wr(OFF_TX_FIFO_LEVELS, 32'hFFFF_FFFF, RESP_OKAY);
        wr(OFF_RX_FIFO_LEVELS, 32'hFFFF_FFFF, RESP_OKAY);
        wr(OFF_RX_DATAPATH_CONTROL, 32'h7FFF_FFFF, RESP_OKAY);
        rd(OFF_RX_DATAPATH_CONTROL, 32'h0, RESP_OKAY);
        rd(OFF_TX_FIFO_LEVELS, 32'h0000_1200, RESP_OKAY);
        // skip bit written without its byte lane has no effect
        s_axi_wstrb <= 4'h7;
        wr(OFF_RX_DATAPATH_CONTROL, 32'h8000_0000, RESP_OKAY);
        s_axi_wstrb <= 4'hF;
        rd(OFF_RX_DATAPATH_CONTROL, 32'h0, RESP_OKAY);
        // three dwords written, well inside the free count
        pulse(HOST_WR, 3);
        pulse(TX_ST_PUSH, 2);
        pulse(TX_ST_POP, 1);
        rd(OFF_TX_FIFO_LEVELS, 32'h0001_11F4, RESP_OKAY);
        // transmit buffer fills while the mac stalls, then drains whole
        stall <= 1;
        tx_fifo_in <= {1'b1, 1'b0, 32'hA5A5_0000};
        do @(negedge clock); while (tx_fifo_ready !== 1'b0 && tx_in < 600);
        @(posedge clock);
        tx_fifo_in.valid <= 0;
        chk(tx_in, TX_BUF_WORDS);
        // words moved out free host fifo room; the full mac-side buffer stays unseen
        rd(OFF_TX_FIFO_LEVELS, 32'h0001_11F4 + 32'(TX_BUF_BYTES), RESP_OKAY);
        stall <= 0;
        for (int i = 0; i < 600 && tx_taken < TX_BUF_WORDS; i++) @(posedge clock);
        chk(tx_taken, TX_BUF_WORDS);
        chk(tx_seen, 32'hA5A5_0000);
        // one three-word frame reaches the receive data fifo
        efbl_mac_model_inst.send(3);
        repeat (6) @(posedge clock);
        chk(rx_words, 3);
        chk(rx_seen[31:0], 32'h2);
        chk({31'h0, rx_seen[32]}, 32'h1);
        chk(pushes, 1);
        rd(OFF_RX_FIFO_LEVELS, 32'h0001_000C, RESP_OKAY);
        pulse(RX_ST_POP, 1);
        // skip with the head word absent, then one last word drained; no host reads meanwhile
        wr(OFF_RX_DATAPATH_CONTROL, 32'h8000_0000, RESP_OKAY);
        rd(OFF_RX_DATAPATH_CONTROL, 32'h8000_0000, RESP_OKAY);
        @(posedge clock);
        {rx_head_valid, rx_head_last} <= 2'b11;
        @(posedge clock);
        {rx_head_valid, rx_head_last} <= 2'b00;
        repeat (2) @(posedge clock);
        chk(drains, 1);
        rd(OFF_RX_DATAPATH_CONTROL, 32'h0, RESP_OKAY);
        rd(OFF_RX_FIFO_LEVELS, 32'h0000_0008, RESP_OKAY);
        pulse(HOST_RD, 2);
        rd(OFF_RX_FIFO_LEVELS, 32'h0, RESP_OKAY);
        // overrun with the data fifo refusing: later frames are lost and counted
        rx_fifo_ready <= 0;
        efbl_mac_model_inst.send(RX_BUF_WORDS + 8);
        repeat (4) @(posedge clock);
        rd(OFF_RX_FIFO_LEVELS, 32'h0, RESP_OKAY);
        lost0 = rx_lost_frames;
        efbl_mac_model_inst.send(2);
        efbl_mac_model_inst.send(2);
        repeat (4) @(posedge clock);
        chk(rx_lost_frames - lost0, 32'h2);
        rx_fifo_ready <= 1;
        repeat (40) @(posedge clock);
        // only the words that fit the receive buffer come through
        chk(rx_seen[31:0], 32'h2 + 32'(RX_BUF_WORDS));
        pulse(HOST_RD, 1);
        lost0 = rx_lost_frames;
        efbl_mac_model_inst.send(2);
        repeat (4) @(posedge clock);
        chk(rx_lost_frames, lost0);
        chk(rx_seen[31:0], 32'h30);
        summarize();
    end
endmodule // ethernet_fifo_buffering_levels_test
